// File: hdl/cer_pkg.sv
package cer_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_SELECT = 8'h04;
    localparam logic [7:0] OFF_OPTS   = 8'h08;
    localparam logic [7:0] OFF_NEDGE  = 8'h0C;
    localparam logic [7:0] OFF_TARGET = 8'h10;
    localparam logic [7:0] OFF_COUNT  = 8'h14;
    localparam logic [7:0] OFF_STREAM = 8'h18;
    // Field positions and codes
    localparam int         OPT_RISING   = 0;
    localparam int         OPT_SINGLE   = 2;
    localparam logic [31:0] SEL_CONDRST = 32'h0000_000C;
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam int         NUM_LINES    = 8;
    localparam int         LINE_W       = 3;
    // Service timing
    localparam int         CLK_MHZ      = 125;
    localparam int         SVC_TIME_NS  = 14000;
    localparam int         SVC_CYCLES   = SVC_TIME_NS * CLK_MHZ / 1000;
    localparam int         SVC_W        = 11;
    localparam logic [SVC_W-1:0] SVC_LAST =
        SVC_W'(SVC_CYCLES - 1);
endpackage

// File: hdl/cer_sync.sv
`timescale 1ns/1ps
module cer_sync
    import cer_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } cer_sync_s;
    cer_sync_s st;
    cer_sync_s next_st;
    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign dout = st.s2;
endmodule // cer_sync

// File: hdl/cer_svc.sv
`timescale 1ns/1ps
module cer_svc
    import cer_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic edge_seen,
    input  wire logic stream_active,
    output logic      pending,
    output logic      done
);
    // Single service slot, preempted only by streaming, with its own pending flag
    typedef struct packed {
        logic             pend;
        logic             busy;
        logic             fin;
        logic [SVC_W-1:0] cnt;
    } cer_svc_s;
    cer_svc_s st;
    cer_svc_s next_st;
    always_comb begin
        next_st = st;
        next_st.fin = 1'b0;
        if (edge_seen && !st.pend) begin
            next_st.pend = 1'b1;
        end
        if (st.busy) begin
            // Stream servicing preempts: the count simply stalls
            if (!stream_active) begin
                if (st.cnt == SVC_LAST) begin
                    next_st.busy = 1'b0;
                    next_st.pend = 1'b0;
                    next_st.fin  = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
        end else if (st.pend) begin
            next_st.busy = 1'b1;
            next_st.cnt  = '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign pending = st.pend;
    assign done    = st.fin;
endmodule // cer_svc

// File: hdl/cer_top.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - Function active only when feature select holds twelve.
// - Enable register: 0 stops, 1 starts the function.
// - After N qualifying edges, issue reset to the target feature.
// - Option bit 0 picks polarity: 1 rising, 0 falling.
// - Option bit 2 set gives one reset only; clear repeats.
// - Second config register holds N edges between resets.
// - Third config register holds target line number.
// - Each reset forces the target's count to zero.
// - Count register reads the present edge count.
// - No update operations; config only changes while disabled.
// - Service keeps up with edge rate ceilings, lower when streaming.
// - Both transitions are serviced, whatever polarity is counted.
// - Edge sets pending flag; cleared on completion; extra edges lost.
// - Service runs 14 us to completion; only streaming preempts.
module cer_top
    import cer_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 line_in,
    output logic      [NUM_LINES-1:0] target_clear,
    output logic                      svc_pending
);
    typedef struct packed {
        logic                 enable;
        logic [31:0]          select;
        logic [31:0]          opts;
        logic [31:0]          nedge;
        logic [31:0]          target;
        logic [31:0]          count;
        logic                 stream;
        logic                 fired;
        logic                 prev;
        logic                 armed;
        logic [31:0]          rdata;
        logic                 rdy;
        logic                 err;
        logic [NUM_LINES-1:0] clr;
        logic                 pend;
    } cer_top_s;

    cer_top_s st;
    cer_top_s next_st;
    logic     line_s;
    logic     svc_pend;
    logic     svc_done;
    logic     any_edge;
    logic     active;
    logic     qual;
    logic     setup;

    // Pin crosses into pclk domain
    cer_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (line_in),
        .dout    (line_s)
    );

    assign any_edge = st.armed && (line_s != st.prev);
    assign active   = st.enable && (st.select == SEL_CONDRST);

    // Edges are qualified when their service completes, as firmware would
    cer_svc u_svc (
        .pclk          (pclk),
        .presetn       (presetn),
        .edge_seen     (any_edge && active),
        .stream_active (st.stream),
        .pending       (svc_pend),
        .done          (svc_done)
    );

    function automatic logic is_reg(input logic [7:0] a);
        return a == OFF_ENABLE || a == OFF_SELECT || a == OFF_OPTS ||
               a == OFF_NEDGE || a == OFF_TARGET || a == OFF_COUNT ||
               a == OFF_STREAM;
    endfunction

    // Polarity of the serviced edge is the level now held
    logic edge_rise;
    logic edge_pol_q;
    typedef struct packed {
        logic pol;
    } cer_pol_s;
    cer_pol_s pst;
    cer_pol_s next_pst;
    always_comb begin
        next_pst = pst;
        if (any_edge && active && !svc_pend) begin
            next_pst.pol = line_s;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst <= '0;
        end else begin
            pst <= next_pst;
        end
    end
    assign edge_rise = pst.pol;
    assign edge_pol_q = st.opts[OPT_RISING];
    assign qual = svc_done && active && (edge_rise == edge_pol_q);

    assign setup = psel && !penable;

    always_comb begin
        next_st       = st;
        next_st.prev  = line_s;
        next_st.armed = 1'b1;
        next_st.clr   = '0;
        next_st.pend  = svc_pend;
        next_st.rdy   = 1'b0;
        next_st.err   = 1'b0;
        // Zero-wait APB: answer in the cycle after setup
        if (setup) begin
            next_st.rdy = 1'b1;
            next_st.err = !is_reg(paddr);
            next_st.rdata = '0;
            if (!pwrite) begin
                unique case (paddr)
                    OFF_ENABLE: next_st.rdata = {31'h0, st.enable};
                    OFF_SELECT: next_st.rdata = st.select;
                    OFF_OPTS:   next_st.rdata = st.opts;
                    OFF_NEDGE:  next_st.rdata = st.nedge;
                    OFF_TARGET: next_st.rdata = st.target;
                    OFF_COUNT:  next_st.rdata = st.count;
                    OFF_STREAM: next_st.rdata = {31'h0, st.stream};
                    default:    next_st.rdata = '0;
                endcase
            end
        end
        if (!active && qual) begin
            next_st.count = st.count;
        end else if (qual && !st.fired) begin
            if (st.count + 32'h0000_0001 >= st.nedge) begin
                // Zero N treated as one edge per reset
                next_st.clr[st.target[LINE_W-1:0]] = 1'b1;
                next_st.count = RST_ZERO;
                if (st.opts[OPT_SINGLE]) begin
                    next_st.fired = 1'b1;
                    next_st.count = st.count + 32'h0000_0001;
                end
            end else begin
                next_st.count = st.count + 32'h0000_0001;
            end
        end else if (qual) begin
            next_st.count = st.count + 32'h0000_0001;
        end
        if (st.rdy && psel && penable && pwrite) begin
            unique case (paddr)
                OFF_ENABLE: begin
                    next_st.enable = pwdata[0];
                    if (pwdata[0] && !st.enable) begin
                        next_st.count = RST_ZERO;
                        next_st.fired = 1'b0;
                    end
                end
                // Config writes ignored while running
                OFF_SELECT: if (!st.enable) next_st.select = pwdata;
                OFF_OPTS:   if (!st.enable) next_st.opts   = pwdata;
                OFF_NEDGE:  if (!st.enable) next_st.nedge  = pwdata;
                OFF_TARGET: if (!st.enable) next_st.target = pwdata;
                OFF_STREAM: next_st.stream = pwdata[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata       = st.rdata;
    assign pready       = st.rdy;
    assign pslverr      = st.err;
    assign target_clear = st.clr;
    assign svc_pending  = st.pend;

    a_sel_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (st.select != SEL_CONDRST) |=> (target_clear == '0))
        else $error("clear issued with wrong feature select");
    a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !st.enable |=> (target_clear == '0))
        else $error("clear issued while disabled");
    a_clear_cause: assert property (@(posedge pclk) disable iff (!presetn)
        (target_clear != '0) |-> $past(qual))
        else $error("clear without qualifying edge");
    a_one_hot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(target_clear))
        else $error("more than one target cleared");
    a_single_once: assert property (@(posedge pclk) disable iff (!presetn)
        st.fired && st.enable |-> (next_st.clr == '0))
        else $error("single mode cleared twice");
    a_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        st.enable && $past(st.enable) |-> $stable(st.nedge))
        else $error("config changed while enabled");
    a_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(svc_pend) |=> svc_pend[*8])
        else $error("service ended too early");
    a_rep_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (next_st.clr != '0) && !st.opts[OPT_SINGLE]
        |=> (st.count == '0))
        else $error("count not rezeroed on reset");
    a_read_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == OFF_COUNT
        |=> prdata == $past(st.count))
        else $error("count read mismatch");
    c_clear: cover property (@(posedge pclk) target_clear != '0);
    c_single: cover property (@(posedge pclk) st.fired);
    c_stream: cover property (@(posedge pclk) st.stream && svc_pend);
endmodule // cer_top

// File: verification/cer_far.sv
`timescale 1ns/1ps
module cer_far
    import cer_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [NUM_LINES-1:0] target_clear,
    output logic                      line_in
);
    logic [7:0]  clr_cnt [NUM_LINES];
    logic [15:0] tgt_cnt [NUM_LINES];

    initial line_in = 1'b0;

    // Target features count cycles; a clear pulse forces zero
    always_ff @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < NUM_LINES; i++) begin
            if (!presetn) begin
                clr_cnt[i] <= 8'h00;
                tgt_cnt[i] <= 16'h0000;
            end else if (target_clear[i]) begin
                clr_cnt[i] <= clr_cnt[i] + 8'h01;
                tgt_cnt[i] <= 16'h0000;
            end else begin
                tgt_cnt[i] <= tgt_cnt[i] + 16'h0001;
            end
        end
    end

    // Edges change right after a clock edge, never two in one step
    task automatic toggle();
        @(posedge pclk);
        line_in <= ~line_in;
    endtask
endmodule // cer_far

// File: verification/conditional_edge_reset_tb.sv
`timescale 1ns/1ps
module conditional_edge_reset_tb;
    import cer_pkg::*;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 line_in;
    logic [NUM_LINES-1:0] target_clear;
    logic                 svc_pending;
    int                   error_cnt = 0;
    int                   tests_run = 0;

    always #4 pclk = ~pclk;

    cer_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in),
        .target_clear(target_clear), .svc_pending(svc_pending));
    cer_far i_far (.pclk(pclk), .presetn(presetn),
        .target_clear(target_clear), .line_in(line_in));

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stuck();
        error_cnt++;
        $display("[FAIL] %0t wait ran out", $time);
        wrap_up();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) stuck();
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(q, exp);
        check({31'h0, e}, 32'h0000_0000);
    endtask

    // Disable first, since config writes are ignored while running
    task automatic setup(input logic [31:0] sel, input logic [31:0] opt,
                         input logic [31:0] n, input logic [31:0] tgt);
        wr(OFF_ENABLE, 32'h0000_0000);
        wr(OFF_SELECT, sel);
        wr(OFF_OPTS, opt);
        wr(OFF_NEDGE, n);
        wr(OFF_TARGET, tgt);
        wr(OFF_ENABLE, 32'h0000_0001);
    endtask

    // One edge, then wait for its service to finish
    task automatic edge_svc();
        int n;
        n = 0;
        i_far.toggle();
        // Two sync flops, pending flag, then the registered output
        repeat (5) @(posedge pclk);
        while (svc_pending === 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000) stuck();
        repeat (3) @(posedge pclk);
    endtask

    task automatic pulses(input int k);
        repeat (2 * k) edge_svc();
    endtask

    initial begin
        logic [31:0] q;
        logic        e;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 20; a += 4) rd(8'(a), RST_ZERO);
        apb(1'b0, 8'h1C, 32'h0000_0000, q, e);
        check({31'h0, e}, 32'h0000_0001);
        $display("test reset values done");

        setup(SEL_CONDRST, 32'h0000_0000, 32'h0000_0002, 32'h0000_0005);
        wr(OFF_NEDGE, 32'h0000_0007);
        rd(OFF_NEDGE, 32'h0000_0002);
        i_far.toggle();
        repeat (5) @(posedge pclk);
        check({31'h0, svc_pending}, 32'h0000_0001);
        repeat (1800) @(posedge pclk);
        edge_svc();
        pulses(2);
        check({24'h0, i_far.clr_cnt[5]}, 32'h0000_0001);
        rd(OFF_COUNT, 32'h0000_0001);
        pulses(1);
        check({24'h0, i_far.clr_cnt[5]}, 32'h0000_0002);
        rd(OFF_COUNT, 32'h0000_0000);
        $display("test repeating falling done");

        setup(SEL_CONDRST, 32'h0000_0005, 32'h0000_0001, 32'h0000_0000);
        rd(OFF_COUNT, 32'h0000_0000);
        pulses(3);
        check({24'h0, i_far.clr_cnt[0]}, 32'h0000_0001);
        $display("test single rising done");

        setup(32'h0000_000B, 32'h0000_0001, 32'h0000_0001, 32'h0000_0003);
        pulses(2);
        check({24'h0, i_far.clr_cnt[3]}, 32'h0000_0000);
        $display("test other selection done");

        setup(SEL_CONDRST, 32'h0000_0000, 32'h0000_0001, 32'h0000_0007);
        i_far.toggle();
        repeat (20) @(posedge pclk);
        edge_svc();
        check({24'h0, i_far.clr_cnt[7]}, 32'h0000_0000);
        pulses(1);
        check({24'h0, i_far.clr_cnt[7]}, 32'h0000_0001);
        $display("test lost edge done");

        // Streaming stalls the service until it is switched off
        wr(OFF_STREAM, 32'h0000_0001);
        rd(OFF_STREAM, 32'h0000_0001);
        i_far.toggle();
        repeat (1800) @(posedge pclk);
        check({31'h0, svc_pending}, 32'h0000_0001);
        wr(OFF_STREAM, 32'h0000_0000);
        repeat (1760) @(posedge pclk);
        check({31'h0, svc_pending}, 32'h0000_0000);
        check({24'h0, i_far.clr_cnt[7]}, 32'h0000_0001);
        $display("test stream stall done");
        wrap_up();
    end
endmodule // conditional_edge_reset_tb
